// ==== logic/twowire_flag_handling.sv ====
// Two-wire slave controller: address match, byte receive and transmit,
// sticky flags with clock stretching, bus timeout and an APB register file.
// Assumes SCL and SDA arrive from open-drain pads and are asynchronous.
//
// Behaviour
// RULE1: Collision flag clears on START, not repeated START
// RULE2: Software clears collision flag after address interrupt
// RULE3: Clear racing address set keeps clock held
// RULE4: Software clears address flag only when safe
// RULE5: Timeout coinciding with START drops the transaction
// RULE6: Respond command clears data flag one cycle later
// RULE7: Software waits one cycle before testing flag
// RULE8: SDA hold option is a single bit
// RULE9: Absent second instance acts as reserved space
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
module twowire_flag_handling
  import twowire_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_out,
  output logic o_scl_oe,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ctrl_t ctrl_reg;
  logic [NUM_FLAGS-1:0] flag_reg, mask_reg, flag_set, flag_clr;
  logic [6:0] own_addr_reg;
  logic [7:0] tx_data_reg, rx_data_reg, shift_reg;
  logic [1:0] scl_sync_reg, sda_sync_reg;
  logic scl_prev_reg, sda_prev_reg;
  logic hold_reg, busy_reg, dif_pend_reg, is_addr_reg, tx_mode_reg, sda_want_reg;
  logic [3:0] bit_cnt_reg;
  logic [$clog2(SDA_HOLD_CYCLES+1)-1:0] hold_cnt_reg;
  logic [$clog2(TIMEOUT_CYCLES+1)-1:0] to_cnt_reg;
  state_t state_reg;
  logic wr_en, start_det, stop_det, scl_rise, scl_fall, timeout_ev, drop, addr_match;
  logic cmd_respond, w1c_stop_addr;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  // Two flops before any logic sees the pins
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else if (i_ce) begin
      scl_sync_reg <= {scl_sync_reg[0], i_scl};
      sda_sync_reg <= {sda_sync_reg[0], i_sda};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  // Bus conditions, seen only while enabled
  assign scl_rise = ctrl_reg.enable & scl_sync_reg[1] & ~scl_prev_reg;
  assign scl_fall = ctrl_reg.enable & ~scl_sync_reg[1] & scl_prev_reg;
  assign start_det = ctrl_reg.enable & scl_sync_reg[1] & scl_prev_reg
                     & sda_prev_reg & ~sda_sync_reg[1];
  assign stop_det = ctrl_reg.enable & scl_sync_reg[1] & scl_prev_reg
                    & ~sda_prev_reg & sda_sync_reg[1];
  // RULE5: timeout with START
  assign drop = start_det & timeout_ev;
  assign addr_match = (shift_reg[7:1] == own_addr_reg);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Write lands only on the access edge where ready is seen high
  assign wr_en = i_psel & i_penable & i_pwrite & o_pready;
  assign cmd_respond = wr_en & (i_paddr == OFF_CMD) & (i_pwdata[1:0] == CMD_RESPOND);
  assign w1c_stop_addr = wr_en & (i_paddr == OFF_STATUS) & i_pwdata[FLG_STOP_ADDR];

  // One wait-free access: ready and read data are registered at the end of the setup cycle
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
      if (i_psel && !i_penable && !i_pwrite) begin
        case (i_paddr)
          OFF_CTRL: o_prdata <= {29'h0000_0000, ctrl_reg};
          OFF_STATUS: o_prdata <= {25'h000_0000, scl_sync_reg[1], busy_reg, hold_reg,
                                   flag_reg};
          OFF_MASK: o_prdata <= {28'h000_0000, mask_reg};
          OFF_OWN_ADDR: o_prdata <= {25'h000_0000, own_addr_reg};
          OFF_DATA: o_prdata <= {24'h00_0000, rx_data_reg};
          // RULE9: second instance reads zero
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software-written configuration; STATUS and CMD writes act in the flag logic, anything else is a reserved location
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ctrl_reg <= CTRL_RST;
      mask_reg <= MASK_RST;
      own_addr_reg <= OWN_ADDR_RST;
      tx_data_reg <= DATA_RST;
    end else if (i_ce && wr_en) begin
      case (i_paddr)
        // RULE8: one-bit hold option
        OFF_CTRL: ctrl_reg <= ctrl_t'(i_pwdata[2:0]);
        OFF_MASK: mask_reg <= i_pwdata[NUM_FLAGS-1:0];
        OFF_OWN_ADDR: own_addr_reg <= i_pwdata[6:0];
        OFF_DATA: tx_data_reg <= i_pwdata[7:0];
        // RULE9: writes ignored here
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    flag_clr = (wr_en && i_paddr == OFF_STATUS) ? i_pwdata[NUM_FLAGS-1:0] : '0;
    // RULE6: delayed data flag clear
    flag_clr[FLG_DATA] = flag_clr[FLG_DATA] | dif_pend_reg;
    // RULE1: also cleared by START, not by repeated START
    flag_clr[FLG_COLL] = flag_clr[FLG_COLL] | (start_det & ~busy_reg);
  end

  // Set beats clear, so an event in the clearing cycle is kept
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
          flag_reg[gi] <= 1'b0;
        end else if (i_ce) begin
          flag_reg[gi] <= flag_set[gi] | (flag_reg[gi] & ~flag_clr[gi]);
        end
      end
    end
  endgenerate

  // Respond command retires the data flag on the next edge, not this one
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      dif_pend_reg <= 1'b0;
      o_irq <= 1'b0;
    end else if (i_ce) begin
      // RULE6: one-cycle late clear
      dif_pend_reg <= cmd_respond;
      o_irq <= |((flag_set | (flag_reg & ~flag_clr)) & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Bus timeout
  // ----------------------------------------------------------------
  // Counts a busy bus with SCL stuck low
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      to_cnt_reg <= '0;
    end else if (i_ce) begin
      if (!ctrl_reg.timeout_en || !busy_reg || scl_sync_reg[1] || timeout_ev) begin
        to_cnt_reg <= '0;
      end else begin
        to_cnt_reg <= to_cnt_reg + 1'b1;
      end
    end
  end
  assign timeout_ev = ctrl_reg.timeout_en && (to_cnt_reg == TIMEOUT_CYCLES[$bits(to_cnt_reg)-1:0]);

  // ----------------------------------------------------------------
  // Slave byte engine
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_reg <= S_IDLE;
      busy_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rx_data_reg <= 8'h00;
      is_addr_reg <= 1'b0;
      tx_mode_reg <= 1'b0;
      sda_want_reg <= 1'b0;
      flag_set <= '0;
    end else if (i_ce) begin
      flag_set <= '0;
      if (drop || timeout_ev || stop_det) begin
        // RULE5: transaction dropped
        state_reg <= S_IDLE;
        busy_reg <= 1'b0;
        sda_want_reg <= 1'b0;
        flag_set[FLG_TIMEOUT] <= timeout_ev;
      end else if (start_det) begin
        state_reg <= S_SHIFT;
        busy_reg <= 1'b1;
        bit_cnt_reg <= 4'h0;
        is_addr_reg <= 1'b1;
        tx_mode_reg <= 1'b0;
        sda_want_reg <= 1'b0;
      end else begin
        case (state_reg)
          S_SHIFT: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              // Released a one but the bus reads zero
              flag_set[FLG_COLL] <= tx_mode_reg & ~sda_want_reg & ~sda_sync_reg[1];
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              sda_want_reg <= 1'b0;
              if (is_addr_reg && !addr_match) begin
                state_reg <= S_IDLE;
              end else begin
                state_reg <= S_WAIT;
                flag_set[FLG_STOP_ADDR] <= is_addr_reg;
                flag_set[FLG_DATA] <= ~is_addr_reg;
                if (is_addr_reg) begin
                  tx_mode_reg <= shift_reg[0];
                end else if (!tx_mode_reg) begin
                  rx_data_reg <= shift_reg;
                end
              end
            end else if (scl_fall && tx_mode_reg) begin
              sda_want_reg <= ~shift_reg[7];
            end
          end
          S_WAIT: begin
            // Clock stretched until software releases the hold
            if (!hold_reg && flag_set == '0) begin
              state_reg <= S_ACK;
              sda_want_reg <= is_addr_reg | ~tx_mode_reg;
            end
          end
          S_ACK: begin
            if (scl_rise && tx_mode_reg && !is_addr_reg && sda_sync_reg[1]) begin
              state_reg <= S_IDLE;
            end else if (scl_fall) begin
              state_reg <= S_SHIFT;
              bit_cnt_reg <= 4'h0;
              is_addr_reg <= 1'b0;
              shift_reg <= tx_data_reg;
              sda_want_reg <= tx_mode_reg & ~tx_data_reg[7];
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock stretch hold
  // ----------------------------------------------------------------
  // A flag clear racing the address set leaves the hold in place,
  // which holds SCL until a later address-flag clear, the respond command, STOP, START or a timeout.
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      hold_reg <= 1'b0;
    end else if (i_ce) begin
      if (drop || timeout_ev || stop_det || start_det) begin
        hold_reg <= 1'b0;
      end else if (flag_set[FLG_STOP_ADDR] || flag_set[FLG_DATA]) begin
        hold_reg <= 1'b1;
      // RULE3: racing clear ignored
      end else if (cmd_respond || (w1c_stop_addr && !flag_set[FLG_STOP_ADDR])) begin
        hold_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Open-drain pin drivers
  // ----------------------------------------------------------------
  // With the hold option SDA changes only after SCL has been low a while
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      hold_cnt_reg <= '0;
      o_sda_oe <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_out <= 1'b0;
      o_scl_out <= 1'b0;
    end else if (i_ce) begin
      o_scl_oe <= hold_reg & (state_reg == S_WAIT);
      if (scl_sync_reg[1]) begin
        hold_cnt_reg <= '0;
      end else if (hold_cnt_reg != SDA_HOLD_CYCLES[$bits(hold_cnt_reg)-1:0]) begin
        hold_cnt_reg <= hold_cnt_reg + 1'b1;
      end
      // RULE8: single-bit hold select
      if (!ctrl_reg.sda_hold_option || !busy_reg
          || hold_cnt_reg == SDA_HOLD_CYCLES[$bits(hold_cnt_reg)-1:0]) begin
        o_sda_oe <= sda_want_reg & busy_reg & (state_reg != S_IDLE);
      end
    end
  end

endmodule : twowire_flag_handling

// ==== logic/twowire_pkg.sv ====
// Shared constants and types of the two-wire slave flag block.
// Assumes a 200 MHz peripheral clock and 32-bit APB register access.
package twowire_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_OWN_ADDR = 8'h0c;
  localparam logic [7:0] OFF_DATA = 8'h10;
  localparam logic [7:0] OFF_CMD = 8'h14;
  // Window where the absent second controller would sit
  localparam logic [7:0] OFF_SECOND_LO = 8'h40;
  localparam logic [7:0] OFF_SECOND_HI = 8'h7c;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int NUM_FLAGS = 4;
  localparam int FLG_STOP_ADDR = 0;
  localparam int FLG_DATA = 1;
  localparam int FLG_COLL = 2;
  localparam int FLG_TIMEOUT = 3;
  localparam int STAT_HOLD_BIT = 4;
  localparam int STAT_BUSY_BIT = 5;
  localparam int STAT_SCL_BIT = 6;
  localparam logic [1:0] CMD_RESPOND = 2'b11;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [NUM_FLAGS-1:0] MASK_RST = 4'h0;
  localparam logic [6:0] OWN_ADDR_RST = 7'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int CLK_PERIOD_NS = 5;
  localparam int BUS_TIMEOUT_US = 25;
  localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_US * CLK_MHZ;
  localparam int SDA_HOLD_NS = 50;
  localparam int SDA_HOLD_CYCLES = (SDA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sda_hold_option;
    logic timeout_en;
    logic enable;
  } ctrl_t;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_SHIFT = 4'b0010,
    S_WAIT  = 4'b0100,
    S_ACK   = 4'b1000
  } state_t;

endpackage : twowire_pkg

// ==== tb/tw_master.sv ====
// Behavioural two-wire master on the far side of the flag block.
// Assumes the bench resolves the open-drain wires with pull-ups.
`timescale 1ns/10ps
module tw_master (
  input wire logic I_CLK,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_rel,
  output logic o_sda_rel
);
  // Released wires idle high through the pull-ups
  initial begin
    o_scl_rel = 1'b1;
    o_sda_rel = 1'b1;
  end
  // Quarter of the 125 ns link period
  task automatic wq();
    repeat (6) @(posedge I_CLK);
  endtask : wq
  // Release SCL; a stretching slave may keep it low, so wait bounded
  task automatic rise();
    int n;
    o_scl_rel <= 1'b1;
    n = 0;
    do begin
      @(posedge I_CLK);
      n++;
    end while (i_scl !== 1'b1 && n < 4000);
    if (n >= 4000) twowire_flag_handling_tb.tally_and_finish(1'b1);
  endtask : rise
  // One bit: 12 cycles low, 13 high
  task automatic clk_bit(input logic b, output logic r);
    o_sda_rel <= b;
    wq();
    rise();
    repeat (12) @(posedge I_CLK);
    r = i_sda;
    o_scl_rel <= 1'b0;
    wq();
  endtask : clk_bit
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r);
      q[i] = r;
    end
  endtask : xfer
  // SDA falls while SCL high; also serves as repeated start
  task automatic start();
    o_sda_rel <= 1'b1;
    wq();
    rise();
    wq();
    o_sda_rel <= 1'b0;
    wq();
    o_scl_rel <= 1'b0;
    wq();
  endtask : start
  task automatic stop();
    o_sda_rel <= 1'b0;
    wq();
    rise();
    wq();
    o_sda_rel <= 1'b1;
    wq();
  endtask : stop
endmodule : tw_master

// ==== tb/twowire_flag_handling_properties.sv ====
// Checker for the two-wire flag block: APB timing, pins and reserved space.
// Assumes one clock domain and a bind onto the top module's ports.
`timescale 1ns/10ps
module twowire_flag_checker
  import twowire_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_scl_out,
  input wire logic o_sda_out
);
  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);
  sequence s_setup;
    i_psel && !i_penable && i_ce;
  endsequence
  sequence s_rd_status;
    s_setup ##0 (!i_pwrite && i_paddr == OFF_STATUS);
  endsequence
  // Completed write of the respond code
  sequence s_respond;
    i_ce && i_psel && i_penable && i_pwrite && o_pready && i_paddr == OFF_CMD
      && i_pwdata[1:0] == CMD_RESPOND;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_READY_AFTER_SETUP: assert property (s_setup |=> o_pready)
    else $error("no ready after setup");
  AST_READY_ONE_CYCLE: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  AST_NO_SLVERR: assert property (!o_pslverr)
    else $error("slave error raised");
  AST_OPEN_DRAIN: assert property (!o_scl_out && !o_sda_out)
    else $error("pin driven high");
  AST_IDLE_RDATA: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside access");
  AST_GAP_READ_ZERO: assert property (s_setup ##0 (!i_pwrite &&
    i_paddr >= OFF_SECOND_LO && i_paddr <= OFF_SECOND_HI) |=> o_prdata == 32'h0)
    else $error("absent instance reads nonzero");
  AST_CTRL_WIDTH: assert property (s_setup ##0 (!i_pwrite &&
    i_paddr == OFF_CTRL) |=> o_prdata[31:3] == 29'h0)
    else $error("control wider than three bits");
  AST_RESPOND_LAG: assert property (s_respond ##3 s_rd_status
    |=> !o_prdata[FLG_DATA])
    else $error("data flag not cleared");
endmodule : twowire_flag_checker

// ==== tb/twowire_flag_handling_tb.sv ====
// Bench for the two-wire flag block: APB master tasks and a bus master model.
// Assumes the checker and the master model are compiled first.
`timescale 1ns/10ps
bind twowire_flag_handling twowire_flag_checker twowire_flag_checker_inst (
  .I_CLK(I_CLK), .I_RESETN(I_RESETN), .i_ce(i_ce), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_scl_out(o_scl_out), .o_sda_out(o_sda_out));
module twowire_flag_handling_tb;
  import twowire_pkg::*;
  logic I_CLK = 1'b0;
  logic I_RESETN = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq, m_scl, m_sda, r;
  logic [7:0] q;
  wire logic scl, sda;
  int miscompares = 0;
  int checked = 0;
  logic [7:0] regs [4] = '{OFF_CTRL, OFF_MASK, OFF_OWN_ADDR, OFF_DATA};
  always #2.5 I_CLK = ~I_CLK;
  // Wired-AND with pull-ups
  assign scl = m_scl & ~scl_oe;
  assign sda = m_sda & ~sda_oe;
  // Short timeout keeps the run brief
  twowire_flag_handling #(.TIMEOUT_CYCLES(50)) twowire_flag_handling_inst (
    .I_CLK(I_CLK), .I_RESETN(I_RESETN), .i_ce(ce), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_scl(scl), .i_sda(sda),
    .o_scl_out(scl_out), .o_scl_oe(scl_oe), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .o_irq(irq));
  tw_master tw_master_inst (.I_CLK(I_CLK), .i_scl(scl), .i_sda(sda),
    .o_scl_rel(m_scl), .o_sda_rel(m_sda));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish(input bit hung);
    if (hung) miscompares++;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // No release at the end, so transfers can run back to back
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge I_CLK);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge I_CLK);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) tally_and_finish(1'b1);
    rv = prdata;
  endtask : apb
  task automatic idle();
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge I_CLK);
  endtask : idle
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    idle();
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    idle();
  endtask : wr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge I_CLK);
      n++;
    end
    if (n >= 2000) tally_and_finish(1'b1);
  endtask : wait_irq
  // Lands a flag clear on the very edge that sets the address flag:
  // fall seen one edge late, two sync flops, one flop of flag_set
  task automatic race_clear();
    int falls;
    int n;
    logic last;
    falls = 0;
    n = 0;
    last = scl;
    while (falls < 8 && n < 1000) begin
      @(posedge I_CLK);
      n++;
      if (last === 1'b1 && scl === 1'b0) falls++;
      last = scl;
    end
    if (n >= 1000) tally_and_finish(1'b1);
    @(posedge I_CLK);
    wr(OFF_STATUS, 32'h1);
  endtask : race_clear
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge I_CLK);
    I_RESETN <= 1'b1;
    @(posedge I_CLK);
    foreach (regs[i]) begin
      rd(regs[i]);
      chk(rv, 32'h0, "reset value");
    end
    rd(OFF_STATUS);
    chk(rv, 32'h40, "status reset");
    // Only three control bits exist; absent instance ignores writes
    wr(OFF_CTRL, 32'hffffffff);
    wr(OFF_SECOND_LO, 32'h0);
    rd(OFF_CTRL);
    chk(rv, 32'h7, "control width");
    rd(OFF_SECOND_LO);
    chk(rv, 32'h0, "absent instance");
    rd(OFF_SECOND_HI);
    chk(rv, 32'h0, "absent instance top");
    rd(8'h20);
    chk(rv, 32'h0, "unmapped read");
    // Address match holds SCL until the flag is cleared
    wr(OFF_CTRL, 32'h1);
    wr(OFF_OWN_ADDR, 32'h2a);
    wr(OFF_MASK, 32'h3);
    wr(OFF_DATA, 32'hff);
    tw_master_inst.start();
    fork
      tw_master_inst.xfer(8'h54, q);
      race_clear();
    join
    rd(OFF_STATUS);
    chk(rv & 32'h7f, 32'h31, "racing clear keeps flag and hold");
    wr(OFF_STATUS, 32'h5);
    rd(OFF_STATUS);
    chk(rv & 32'h7f, 32'h20, "hold released");
    chk(32'(irq), 32'h0, "irq after clear");
    tw_master_inst.clk_bit(1'b1, r);
    chk(32'(r), 32'h0, "address ack");
    tw_master_inst.xfer(8'ha5, q);
    wait_irq();
    rd(OFF_DATA);
    chk(rv, 32'ha5, "received byte");
    // Flag still reads set right after the respond command
    apb(1'b1, OFF_CMD, 32'h3);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(32'(rv[FLG_DATA]), 32'h1, "flag one cycle on");
    apb(1'b0, OFF_STATUS, 32'h0);
    idle();
    chk(32'(rv[FLG_DATA]), 32'h0, "flag cleared");
    tw_master_inst.clk_bit(1'b1, r);
    chk(32'(r), 32'h0, "data ack");
    // Read transfer; master pulls SDA low against the slave's ones
    tw_master_inst.start();
    tw_master_inst.xfer(8'h55, q);
    wait_irq();
    rd(OFF_STATUS);
    chk(rv & 32'h7f, 32'h31, "address flag and hold");
    wr(OFF_STATUS, 32'h5);
    tw_master_inst.clk_bit(1'b1, r);
    tw_master_inst.xfer(8'h00, q);
    rd(OFF_STATUS);
    chk(32'(rv[FLG_COLL]), 32'h1, "collision set");
    wr(OFF_CMD, 32'h3);
    tw_master_inst.start();
    rd(OFF_STATUS);
    chk(32'(rv[FLG_COLL]), 32'h1, "kept on repeated start");
    tw_master_inst.stop();
    tw_master_inst.start();
    rd(OFF_STATUS);
    chk(32'(rv[FLG_COLL]), 32'h0, "cleared on start");
    // Timeout flag: masked, then unmasked, then cleared
    wr(OFF_STATUS, 32'hf);
    wr(OFF_MASK, 32'h0);
    wr(OFF_CTRL, 32'h3);
    // Clock enable low freezes the timeout counter
    ce <= 1'b0;
    repeat (120) @(posedge I_CLK);
    ce <= 1'b1;
    rd(OFF_STATUS);
    chk(32'(rv[FLG_TIMEOUT]), 32'h0, "frozen by clock enable");
    repeat (120) @(posedge I_CLK);
    chk(32'(irq), 32'h0, "masked irq");
    wr(OFF_MASK, 32'h8);
    wait_irq();
    rd(OFF_STATUS);
    chk(32'(rv[FLG_TIMEOUT]), 32'h1, "timeout flag");
    wr(OFF_CTRL, 32'h1);
    wr(OFF_STATUS, 32'h8);
    @(posedge I_CLK);
    chk(32'(irq), 32'h0, "irq cleared");
    tw_master_inst.stop();
    tally_and_finish(1'b0);
  end
endmodule : twowire_flag_handling_tb
